// >>> rtl/alarm_irq_latch.sv
// loopback and receive alarm interrupt latch with an AXI4-Lite register slave
`timescale 1ns/10ps
module alarm_irq_latch
  import alarm_irq_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic [LB_W-1:0]   loopback_status,
  input  wire logic [RX_W-1:0]   rx_t3_status,
  output logic                   irq,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic              aw_ready;
    logic              w_ready;
    logic              ar_ready;
    logic              aw_have;
    logic              w_have;
    logic              b_valid;
    logic              r_valid;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic [1:0]        b_resp;
    logic [1:0]        r_resp;
    logic [31:0]       r_data;
    logic [LB_W-1:0]   lb_mask;
    logic [RX_W-1:0]   rx_mask;
    logic              rise_en;
    logic              fall_en;
    logic              irq;
  } state_s;

  state_s s;
  state_s next_s;

  req_latch_if #(.W(LB_W)) lb_if ();
  req_latch_if #(.W(RX_W)) rx_if ();

  logic            lb_any;
  logic            rx_any;
  logic [5:0]      rd_idx;
  logic [5:0]      wr_idx;
  logic            rd_take;
  logic [LB_W-1:0] lb_clr;
  logic [RX_W-1:0] rx_clr;
  logic            rd_lb_req;
  logic            rd_rx_req;
  logic            rd_hit;
  logic            wr_fire;
  logic            wr_hit;
  logic            wr_lb_mask;
  logic            wr_rx_mask;
  logic            wr_edge_sel;
  logic            irq_any_req;

  logic [REG_W-1:0] rd_word;

  // named views of the request bits
  logic loopback_req_irq_ch_four;
  logic loopback_req_irq_ch_twelve;
  logic loopback_req_irq_ch_sixteen;
  logic loopback_req_irq_ch_twenty;
  logic loopback_req_irq_ch_twentyfour;
  logic loopback_req_irq_ch_twentyeight;
  logic rx_t3_signal_loss_irq;
  logic rx_t3_out_of_frame_irq;
  logic rx_t3_alarm_indication_irq;
  logic rx_t3_idle_detect_irq;

  ////////////////////////////////////////////////////////////////////////////
  // request latches and masking

  assign lb_if.status  = loopback_status;
  assign lb_if.clr     = lb_clr;
  assign lb_if.rise_en = s.rise_en;
  assign lb_if.fall_en = s.fall_en;

  assign rx_if.status  = rx_t3_status;
  assign rx_if.clr     = rx_clr;
  assign rx_if.rise_en = s.rise_en;
  assign rx_if.fall_en = s.fall_en;

  edge_req_latch #(.W(LB_W)) u_lb_latch (
    .mclk (mclk),
    .rst  (rst),
    .lat  (lb_if.latch)
  );

  edge_req_latch #(.W(RX_W)) u_rx_latch (
    .mclk (mclk),
    .rst  (rst),
    .lat  (rx_if.latch)
  );

  irq_any #(.W(LB_W)) u_lb_any (
    .req  (lb_if.req),
    .mask (s.lb_mask),
    .any  (lb_any)
  );

  irq_any #(.W(RX_W)) u_rx_any (
    .req  (rx_if.req),
    .mask (s.rx_mask),
    .any  (rx_any)
  );

  assign loopback_req_irq_ch_four        = lb_if.req[LOOPBACK_REQ_IRQ_CH_FOUR];
  assign loopback_req_irq_ch_twelve      = lb_if.req[LOOPBACK_REQ_IRQ_CH_TWELVE];
  assign loopback_req_irq_ch_sixteen     = lb_if.req[LOOPBACK_REQ_IRQ_CH_SIXTEEN];
  assign loopback_req_irq_ch_twenty      = lb_if.req[LOOPBACK_REQ_IRQ_CH_TWENTY];
  assign loopback_req_irq_ch_twentyfour  = lb_if.req[LOOPBACK_REQ_IRQ_CH_TWENTYFOUR];
  assign loopback_req_irq_ch_twentyeight = lb_if.req[LOOPBACK_REQ_IRQ_CH_TWENTYEIGHT];

  assign rx_t3_signal_loss_irq      = rx_if.req[RX_T3_SIGNAL_LOSS_IRQ - RX_LO];
  assign rx_t3_out_of_frame_irq     = rx_if.req[RX_T3_OUT_OF_FRAME_IRQ - RX_LO];
  assign rx_t3_alarm_indication_irq = rx_if.req[RX_T3_ALARM_INDICATION_IRQ - RX_LO];
  assign rx_t3_idle_detect_irq      = rx_if.req[RX_T3_IDLE_DETECT_IRQ - RX_LO];

  ////////////////////////////////////////////////////////////////////////////
  // read decode and read-clear

  assign rd_idx    = s_axi_araddr[7:2];
  assign wr_idx    = s.aw_addr[7:2];
  assign rd_take   = s_axi_arvalid && s.ar_ready;
  assign rd_lb_req = rd_take && (rd_idx == IDX_LB_REQ);
  assign rd_rx_req = rd_take && (rd_idx == IDX_RX_REQ);

  // only the bits returned by this read are cleared
  always_comb begin
    lb_clr = '0;
    rx_clr = '0;
    if (rd_lb_req) begin
      lb_clr = lb_if.req;
    end
    if (rd_rx_req) begin
      rx_clr = rx_if.req;
    end
  end

  function automatic logic [REG_W-1:0] read_reg(input logic [5:0] idx);
    logic [REG_W-1:0] v;
    v = '0;
    case (idx)
      IDX_RX_STATUS: begin
        v[RX_LO +: RX_W] = rx_t3_status;
      end
      IDX_LB_STATUS: begin
        v[LB_W-1:0] = loopback_status;
      end
      IDX_LB_REQ: begin
        v[LOOPBACK_REQ_IRQ_CH_FOUR]        = loopback_req_irq_ch_four;
        v[LOOPBACK_REQ_IRQ_CH_TWELVE]      = loopback_req_irq_ch_twelve;
        v[LOOPBACK_REQ_IRQ_CH_SIXTEEN]     = loopback_req_irq_ch_sixteen;
        v[LOOPBACK_REQ_IRQ_CH_SIXTEEN - 1] = lb_if.req[LOOPBACK_REQ_IRQ_CH_SIXTEEN - 1];
        v[LOOPBACK_REQ_IRQ_CH_TWENTY]      = loopback_req_irq_ch_twenty;
        v[LOOPBACK_REQ_IRQ_CH_TWENTYFOUR]  = loopback_req_irq_ch_twentyfour;
        v[LOOPBACK_REQ_IRQ_CH_TWENTYEIGHT] = loopback_req_irq_ch_twentyeight;
      end
      IDX_RX_REQ: begin
        v[RX_T3_SIGNAL_LOSS_IRQ]      = rx_t3_signal_loss_irq;
        v[RX_T3_OUT_OF_FRAME_IRQ]     = rx_t3_out_of_frame_irq;
        v[RX_T3_ALARM_INDICATION_IRQ] = rx_t3_alarm_indication_irq;
        v[RX_T3_IDLE_DETECT_IRQ]      = rx_t3_idle_detect_irq;
      end
      IDX_LB_MASK: begin
        v[LB_W-1:0] = s.lb_mask;
      end
      IDX_RX_MASK: begin
        v[RX_LO +: RX_W] = s.rx_mask;
      end
      IDX_EDGE_SEL: begin
        v[EDGE_RISE_BIT] = s.rise_en;
        v[EDGE_FALL_BIT] = s.fall_en;
      end
      default: begin
        v = '0;
      end
    endcase
    return v;
  endfunction : read_reg

  function automatic logic idx_mapped(input logic [5:0] idx);
    logic hit;
    hit = 1'b0;
    case (idx)
      IDX_RX_STATUS, IDX_LB_STATUS, IDX_LB_REQ, IDX_RX_REQ,
      IDX_LB_MASK, IDX_RX_MASK, IDX_EDGE_SEL: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction : idx_mapped

  assign rd_word = read_reg(rd_idx);
  assign rd_hit  = idx_mapped(rd_idx);

  ////////////////////////////////////////////////////////////////////////////
  // write decode

  assign wr_fire = s.aw_have && s.w_have && !s.b_valid;
  assign wr_hit  = idx_mapped(wr_idx);

  // one strobe per writable register, only in the commit cycle;
  // registers live in byte lane 0 and read-only ones ignore writes
  always_comb begin
    wr_lb_mask  = 1'b0;
    wr_rx_mask  = 1'b0;
    wr_edge_sel = 1'b0;
    if (wr_fire && s.w_strb[0]) begin
      case (wr_idx)
        IDX_LB_MASK: begin
          wr_lb_mask = 1'b1;
        end
        IDX_RX_MASK: begin
          wr_rx_mask = 1'b1;
        end
        IDX_EDGE_SEL: begin
          wr_edge_sel = 1'b1;
        end
        default: begin
          wr_edge_sel = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt

  // either group alone is enough to hold the pin
  assign irq_any_req = lb_any || rx_any;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_s = s;

    // write address and data are taken independently, either order
    if (s_axi_awvalid && s.aw_ready) begin
      next_s.aw_have  = 1'b1;
      next_s.aw_addr  = s_axi_awaddr;
      next_s.aw_ready = 1'b0;
    end
    if (s_axi_wvalid && s.w_ready) begin
      next_s.w_have  = 1'b1;
      next_s.w_data  = s_axi_wdata;
      next_s.w_strb  = s_axi_wstrb;
      next_s.w_ready = 1'b0;
    end

    if (s.b_valid && s_axi_bready) begin
      next_s.b_valid  = 1'b0;
      next_s.aw_ready = 1'b1;
      next_s.w_ready  = 1'b1;
    end

    if (wr_fire) begin
      next_s.aw_have = 1'b0;
      next_s.w_have  = 1'b0;
      next_s.b_valid = 1'b1;
      next_s.b_resp  = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (wr_lb_mask) begin
      next_s.lb_mask = s.w_data[LB_W-1:0];
    end
    if (wr_rx_mask) begin
      next_s.rx_mask = s.w_data[RX_LO +: RX_W];
    end
    if (wr_edge_sel) begin
      next_s.rise_en = s.w_data[EDGE_RISE_BIT];
      next_s.fall_en = s.w_data[EDGE_FALL_BIT];
    end

    if (s.r_valid && s_axi_rready) begin
      next_s.r_valid  = 1'b0;
      next_s.ar_ready = 1'b1;
    end
    if (rd_take) begin
      next_s.ar_ready = 1'b0;
      next_s.r_valid  = 1'b1;
      next_s.r_data   = {{(32 - REG_W){1'b0}}, rd_word};
      next_s.r_resp   = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end

    // one cycle behind the request bits, so the pin is a clean flop
    next_s.irq = irq_any_req;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s          <= '0;
      s.aw_ready <= 1'b1;
      s.w_ready  <= 1'b1;
      s.ar_ready <= 1'b1;
      s.lb_mask  <= LB_MASK_RESET;
      s.rx_mask  <= RX_MASK_RESET;
      s.rise_en  <= RISE_RESET;
      s.fall_en  <= FALL_RESET;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign irq           = s.irq;
  assign s_axi_awready = s.aw_ready;
  assign s_axi_wready  = s.w_ready;
  assign s_axi_bvalid  = s.b_valid;
  assign s_axi_bresp   = s.b_resp;
  assign s_axi_arready = s.ar_ready;
  assign s_axi_rvalid  = s.r_valid;
  assign s_axi_rdata   = s.r_data;
  assign s_axi_rresp   = s.r_resp;

endmodule : alarm_irq_latch

// >>> rtl/alarm_irq_pkg.sv
// constants, register map and field layout for the alarm interrupt latch
// Summary of operation
// - latch one loopback request bit per remote loopback status bit at 0BH.
// - edge select at 3FH sets loopback requests on entry, exit or both.
// - set loopback request with mask bit at 31H high drives the interrupt.
// - reading the loopback request register clears every bit set at that read.
// - register 29H holds request bits for the receive alarm status at 00H.
// - interrupt active while a receive request and its 32H mask bit are both 1.
// - receive request bits: 7 signal loss, 6 out of frame, 5 AIS, 4 idle.
// - reading the receive request register clears its set bits.
// - edge select at 3FH also sets receive requests on entry, exit or both.
package alarm_irq_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_RX_STATUS     = 6'h00;
  localparam logic [5:0] IDX_LB_STATUS     = 6'h0B;
  localparam logic [5:0] IDX_LB_REQ        = 6'h28;
  localparam logic [5:0] IDX_RX_REQ        = 6'h29;
  localparam logic [5:0] IDX_LB_MASK       = 6'h31;
  localparam logic [5:0] IDX_RX_MASK       = 6'h32;
  localparam logic [5:0] IDX_EDGE_SEL      = 6'h3F;

  localparam int LB_W  = 7;
  localparam int RX_W  = 4;
  localparam int RX_LO = 4;
  localparam int REG_W = 8;

  // loopback request bit positions
  localparam int LOOPBACK_REQ_IRQ_CH_FOUR         = 0;
  localparam int LOOPBACK_REQ_IRQ_CH_TWELVE       = 1;
  localparam int LOOPBACK_REQ_IRQ_CH_SIXTEEN      = 3;
  localparam int LOOPBACK_REQ_IRQ_CH_TWENTY       = 4;
  localparam int LOOPBACK_REQ_IRQ_CH_TWENTYFOUR   = 5;
  localparam int LOOPBACK_REQ_IRQ_CH_TWENTYEIGHT  = 6;

  // receive request bit positions
  localparam int RX_T3_SIGNAL_LOSS_IRQ       = 7;
  localparam int RX_T3_OUT_OF_FRAME_IRQ      = 6;
  localparam int RX_T3_ALARM_INDICATION_IRQ  = 5;
  localparam int RX_T3_IDLE_DETECT_IRQ       = 4;

  // edge select fields
  localparam int EDGE_RISE_BIT = 1;
  localparam int EDGE_FALL_BIT = 0;

  localparam logic             RISE_RESET    = 1'b1;
  localparam logic             FALL_RESET    = 1'b0;
  localparam logic [LB_W-1:0]  LB_MASK_RESET = 7'h00;
  localparam logic [RX_W-1:0]  RX_MASK_RESET = 4'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : alarm_irq_pkg

// >>> rtl/edge_req_latch.sv
// sticky request bits set on selected edges of a status vector
`timescale 1ns/10ps
module edge_req_latch #(
  parameter int W = 4
) (
  input wire logic  mclk,
  input wire logic  rst,
  req_latch_if.latch lat
);
  typedef struct packed {
    logic [W-1:0] prev;
    logic [W-1:0] req;
  } latch_s;

  latch_s       s;
  latch_s       next_s;
  logic [W-1:0] set;

  always_comb begin
    set = '0;
    if (lat.rise_en) begin
      set = set | (lat.status & ~s.prev);
    end
    if (lat.fall_en) begin
      set = set | (~lat.status & s.prev);
    end
    next_s      = s;
    next_s.prev = lat.status;
    // a new edge in the clearing cycle survives the read
    next_s.req  = (s.req & ~lat.clr) | set;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign lat.req = s.req;
endmodule : edge_req_latch

// >>> rtl/irq_any.sv
// one masked OR of a request group
`timescale 1ns/10ps
module irq_any #(
  parameter int W = 4
) (
  input  wire logic [W-1:0] req,
  input  wire logic [W-1:0] mask,
  output logic              any
);
  assign any = |(req & mask);
endmodule : irq_any

// >>> rtl/req_latch_if.sv
// link between the register block and one edge-triggered request latch
`timescale 1ns/10ps
interface req_latch_if #(
  parameter int W = 4
);
  logic [W-1:0] status;
  logic [W-1:0] clr;
  logic [W-1:0] req;
  logic         rise_en;
  logic         fall_en;

  modport latch (input status, input clr, input rise_en, input fall_en, output req);
  modport ctrl  (output status, output clr, output rise_en, output fall_en, input req);
endinterface : req_latch_if

// >>> verif/alarm_irq_props.sv
// port-level assertions for the alarm interrupt latch
`timescale 1ns/10ps
module alarm_irq_props
  import alarm_irq_pkg::*;
(
  input wire logic            mclk,
  input wire logic            rst,
  input wire logic [LB_W-1:0] loopback_status,
  input wire logic [RX_W-1:0] rx_t3_status,
  input wire logic            irq,
  input wire logic            s_axi_awvalid,
  input wire logic            s_axi_awready,
  input wire logic            s_axi_wvalid,
  input wire logic            s_axi_wready,
  input wire logic [1:0]      s_axi_bresp,
  input wire logic            s_axi_bvalid,
  input wire logic            s_axi_bready,
  input wire logic            s_axi_arvalid,
  input wire logic            s_axi_arready,
  input wire logic [31:0]     s_axi_rdata,
  input wire logic            s_axi_rvalid,
  input wire logic            s_axi_rready
);
  logic [10:0] st;
  assign st = {loopback_status, rx_t3_status};
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  sequence rd_take; s_axi_arvalid && s_axi_arready; endsequence
  // irq is registered, so it trails the clearing read by two samples
  sequence rd_clear; $past(s_axi_arvalid && s_axi_arready, 2); endsequence
  sequence wr_done; $past(s_axi_bvalid); endsequence
  sequence st_moved; $past(st, 2) != $past(st, 3); endsequence
  chk_rd_answer: assert property (rd_take |=> s_axi_rvalid) else $error("read not answered");
  chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
  chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
  chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read overlap");
  chk_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write overlap");
  chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  chk_irq_cause: assert property ($rose(irq) |-> st_moved or wr_done)
    else $error("irq rose without cause");
  chk_irq_clear: assert property ($fell(irq) |-> rd_clear or wr_done)
    else $error("irq fell without cause");
endmodule : alarm_irq_props
bind alarm_irq_latch alarm_irq_props chk_u (
  .mclk, .rst, .loopback_status, .rx_t3_status, .irq, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready
);

// >>> verif/alarm_src.sv
// behavioural alarm detectors that drive the latch status inputs
`timescale 1ns/10ps
module alarm_src
  import alarm_irq_pkg::*;
(
  input  wire logic            mclk,
  input  wire logic            rst,
  input  wire logic [LB_W-1:0] lb_want,
  input  wire logic [RX_W-1:0] rx_want,
  output logic      [LB_W-1:0] loopback_status,
  output logic      [RX_W-1:0] rx_t3_status
);
  // detectors only move on the clock, so status stays synchronous to mclk
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      loopback_status <= '0;
      rx_t3_status    <= '0;
    end else begin
      loopback_status <= lb_want;
      rx_t3_status    <= rx_want;
    end
  end
endmodule : alarm_src

// >>> verif/tb.sv
// self-checking bench for the alarm interrupt latch
`timescale 1ns/10ps
module tb
  import alarm_irq_pkg::*;
;
  logic            mclk, rst, irq;
  logic [LB_W-1:0] lb_want, loopback_status, v, old;
  logic [RX_W-1:0] rx_want, rx_t3_status;
  logic [7:0]      s_axi_awaddr, s_axi_araddr;
  logic [31:0]     s_axi_wdata, s_axi_rdata;
  logic [1:0]      s_axi_bresp, s_axi_rresp;
  logic [3:0]      s_axi_wstrb;
  logic            s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic            s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [33:0]     q[$];
  int              mismatches, num_checks, i, seed = 43862;
  alarm_irq_latch #(.ADDR_W(8)) dut_u (
    .mclk, .rst, .loopback_status, .rx_t3_status, .irq, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .s_axi_awprot(3'h0), .s_axi_arprot(3'h0), .s_axi_wstrb
  );
  alarm_src src_u (.mclk, .rst, .lb_want, .rx_want, .loopback_status, .rx_t3_status);
  ////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  // one bus transfer; ready is raised late so the slave must hold its answer
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
    int n;
    @(posedge mclk);
    q.push_back({r, w ? 32'h0000_0000 : d});
    s_axi_awaddr  <= a;
    s_axi_araddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid  <= w;
    s_axi_arvalid <= !w;
    for (n = 0; n < 40; n++) begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) break;
      s_axi_bready <= s_axi_bvalid;
      s_axi_rready <= s_axi_rvalid;
    end
    if (n == 40) begin
      mismatches++;
      report_and_stop();
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask : xfer
  task automatic settle(input logic x);
    repeat (4) @(posedge mclk);
    chk({33'h0, irq}, {33'h0, x});
  endtask : settle
  always @(posedge mclk) begin
    if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready))
      chk(s_axi_rvalid ? {s_axi_rresp, s_axi_rdata} : {s_axi_bresp, 32'h0}, q.pop_front());
  end
  ////////////////////////////////////////
  initial begin
    rst = 1'b1;
    {lb_want, rx_want, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    xfer(0, 8'hFC, 32'h0000_0002, RESP_OKAY);
    xfer(0, 8'hC4, 32'h0000_0000, RESP_OKAY);
    xfer(0, 8'h04, 32'h0000_0000, RESP_SLVERR);
    xfer(1, 8'h08, 32'h0000_00FF, RESP_SLVERR);
    xfer(1, 8'hC8, 32'h0000_00F0, RESP_OKAY);
    for (i = 0; i < RX_W; i++) begin
      rx_want <= 4'h1 << i;
      settle(1'b1);
      xfer(0, 8'h00, 32'h0000_0010 << i, RESP_OKAY);
      xfer(0, 8'hA4, 32'h0000_0010 << i, RESP_OKAY);
      settle(1'b0);
      rx_want <= 4'h0;
      settle(1'b0);
    end
    xfer(1, 8'hC4, 32'h0000_007F, RESP_OKAY);
    xfer(1, 8'hFC, 32'h0000_0001, RESP_OKAY);
    // a write with lane 0 disabled leaves the mask alone
    s_axi_wstrb <= 4'h0;
    xfer(1, 8'hC4, 32'h0000_0000, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    xfer(0, 8'hC4, 32'h0000_007F, RESP_OKAY);
    lb_want <= 7'h04;
    settle(1'b0);
    xfer(0, 8'h2C, 32'h0000_0004, RESP_OKAY);
    lb_want <= 7'h00;
    settle(1'b1);
    xfer(0, 8'hA0, 32'h0000_0004, RESP_OKAY);
    settle(1'b0);
    // both edges with the mask off: bits still latch but stay quiet
    xfer(1, 8'hFC, 32'h0000_0003, RESP_OKAY);
    xfer(1, 8'hC4, 32'h0000_0000, RESP_OKAY);
    old = 7'h00;
    for (i = 0; i < 4; i++) begin
      v = 7'($random(seed));
      lb_want <= v;
      settle(1'b0);
      xfer(0, 8'hA0, {25'h0, old ^ v}, RESP_OKAY);
      old = v;
    end
    lb_want <= ~old;
    settle(1'b0);
    xfer(1, 8'hC4, 32'h0000_007F, RESP_OKAY);
    settle(1'b1);
    xfer(0, 8'hA0, 32'h0000_007F, RESP_OKAY);
    settle(1'b0);
    rx_want <= 4'h1;
    settle(1'b1);
    xfer(1, 8'hC8, 32'h0000_0000, RESP_OKAY);
    settle(1'b0);
    rx_want <= 4'h0;
    settle(1'b0);
    xfer(0, 8'hA4, 32'h0000_0010, RESP_OKAY);
    report_and_stop();
  end
endmodule : tb
